// >>> capture_glue_defs.svh
/*
  Offsets, field positions, reset values and timing counts for the
  capture unit clock and input selection glue.
  Assumes a 32-bit APB register bus with word-aligned registers.
*/
`ifndef CAPTURE_GLUE_DEFS_SVH
`define CAPTURE_GLUE_DEFS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define CG_OFF_WORD_39 12'h000
`define CG_OFF_WORD_40 12'h004
`define CG_OFF_WORD_43 12'h008
`define CG_OFF_WORD_44 12'h00c
`define CG_OFF_STATUS 12'h010
`define CG_OFF_MODE 12'h014

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define CG_ENABLE_STEP 8
`define CG_SELECT_STEP 8
`define CG_SELECT_WIDTH 3
`define CG_WORD_39_RESET 32'h01010101
`define CG_WORD_40_RESET 32'h00000101
`define CG_WORD_43_RESET 32'h01010101
`define CG_WORD_44_RESET 32'h00000101
`define CG_MODE_RESET 32'h00000000

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CG_FILTER_CYCLES 6
`define CG_SYNC_STAGES 2

`endif

// >>> capture_glue_pkg.sv
/*
  Types shared by the capture unit glue.
  Assumes nothing beyond the defs header.
*/
package capture_glue_pkg;
  typedef enum logic [2:0] {
    SEL_RESERVED0,
    SEL_SYNC,
    SEL_FILTERED
  } input_select_e;
  typedef logic [2:0] select_code_t;
  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACCESS
  } bus_phase_e;
endpackage

// >>> input_sync_filter.sv
/*
  Double synchroniser with a qualification filter for one input.
  Assumes a single clock and asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
`include "capture_glue_defs.svh"

module input_sync_filter #(
  parameter int FILTER_CYCLES = `CG_FILTER_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic pin,
  output logic synced,
  output logic filtered
);
  localparam int CW = $clog2(FILTER_CYCLES + 1);
  logic stage1;
  logic stage2;
  logic [CW-1:0] stable_count;
  wire level_changed = stage2 != filtered;
  wire count_done = stable_count == CW'(FILTER_CYCLES - 1);

  // ---------------------------------------------------------------
  // Synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
    end
  end
  assign synced = stage2;

  // ---------------------------------------------------------------
  // Filter
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stable_count <= '0;
      filtered <= 1'b0;
    end else if (!level_changed) begin
      stable_count <= '0;
    end else if (count_done) begin
      filtered <= stage2;
      stable_count <= '0;
    end else begin
      stable_count <= stable_count + CW'(1);
    end
  end

  pass_after_width_a: assert property (@(posedge clock) disable iff (!reset_n)
    $changed(filtered) |-> $past(stage2, 1) == filtered && $past(level_changed, 1)
      && $past(level_changed, 2) && $past(level_changed, 3) && $past(level_changed, 4)
      && $past(level_changed, 5) && $past(level_changed, 6))
    else $error("filtered output changed before filter width");
  glitch_block_a: assert property (@(posedge clock) disable iff (!reset_n)
    (level_changed && !$past(level_changed)) ##1 !level_changed |-> $stable(filtered))
    else $error("short glitch reached filtered output");
endmodule // input_sync_filter
`default_nettype wire

// >>> capture_unit_clock_gate.sv
/*
  Latch-based clock gate for one capture unit.
  Assumes the enable is driven from clock-domain flip-flops.
*/
`timescale 1ns/10ps
`default_nettype none

module capture_unit_clock_gate (
  input wire logic clock,
  input wire logic enable,
  output logic gated_clock
);
  logic enable_latched;

  // ---------------------------------------------------------------
  // Glitch-free gate
  // ---------------------------------------------------------------
  always_latch begin
    if (!clock) begin
      enable_latched = enable;
    end
  end
  assign gated_clock = clock & enable_latched;
endmodule // capture_unit_clock_gate
`default_nettype wire

// >>> capture_glue.sv
/*
  Capture unit glue: per-unit peripheral bus clock gating, per-input
  synchronised or filtered routing, and the auxiliary pulse output mode
  select, all behind an APB slave.
  Assumes capture pins synchronous-sampled on clock and a 32-bit APB master.
*/
`timescale 1ns/10ps
`default_nettype none
`include "capture_glue_defs.svh"

module capture_glue #(
  parameter int UNITS = 6,
  parameter int FILTER_CYCLES = `CG_FILTER_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [UNITS-1:0] capture_pin,
  output logic [UNITS-1:0] capture_input,
  output logic [UNITS-1:0] capture_unit_clock_enable,
  output logic [UNITS-1:0] capture_unit_clock,
  output logic [UNITS-1:0] auxiliary_pulse_output_mode
);
  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] pin_mux_control_word_39;
  logic [31:0] pin_mux_control_word_40;
  logic [31:0] pin_mux_control_word_43;
  logic [31:0] pin_mux_control_word_44;
  logic [31:0] mode_word;
  logic [UNITS-1:0] synced;
  logic [UNITS-1:0] filtered;
  logic [UNITS-1:0] enable_bit;
  logic [UNITS-1:0] gate_enable;
  capture_glue_pkg::select_code_t select_code [UNITS];

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_value,
                                              input logic [31:0] new_value,
                                              input logic [3:0] strobe);
    logic [31:0] result;
    result = old_value;
    for (int b = 0; b < 4; b++) begin
      if (strobe[b]) begin
        result[b*8 +: 8] = new_value[b*8 +: 8];
      end
    end
    return result;
  endfunction

  // Picks the routed level for one select code
  function automatic logic route_level(input capture_glue_pkg::select_code_t code,
                                       input logic sync_level,
                                       input logic filter_level);
    logic result;
    result = sync_level;
    if (code == capture_glue_pkg::select_code_t'(capture_glue_pkg::SEL_FILTERED)) begin
      result = filter_level;
    end
    return result;
  endfunction

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire write_access = psel && penable && pwrite;
  wire hit_39 = paddr == `CG_OFF_WORD_39;
  wire hit_40 = paddr == `CG_OFF_WORD_40;
  wire hit_43 = paddr == `CG_OFF_WORD_43;
  wire hit_44 = paddr == `CG_OFF_WORD_44;
  wire hit_status = paddr == `CG_OFF_STATUS;
  wire hit_mode = paddr == `CG_OFF_MODE;
  wire mapped = hit_39 || hit_40 || hit_43 || hit_44 || hit_status || hit_mode;
  wire write_ok = write_access && mapped && !hit_status;
  wire [31:0] status_word = {{(32-2*UNITS){1'b0}}, filtered, synced};
  wire [31:0] read_mux = hit_39 ? pin_mux_control_word_39 :
                         hit_40 ? pin_mux_control_word_40 :
                         hit_43 ? pin_mux_control_word_43 :
                         hit_44 ? pin_mux_control_word_44 :
                         hit_status ? status_word :
                         hit_mode ? mode_word : 32'h00000000;

  assign pready = 1'b1;
  assign pslverr = psel && penable && (!mapped || (pwrite && hit_status));

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_mux_control_word_39 <= `CG_WORD_39_RESET;
      pin_mux_control_word_40 <= `CG_WORD_40_RESET;
      pin_mux_control_word_43 <= `CG_WORD_43_RESET;
      pin_mux_control_word_44 <= `CG_WORD_44_RESET;
      mode_word <= `CG_MODE_RESET;
    end else if (write_ok) begin
      if (hit_39) pin_mux_control_word_39 <= merge_bytes(pin_mux_control_word_39, pwdata, pstrb);
      if (hit_40) pin_mux_control_word_40 <= merge_bytes(pin_mux_control_word_40, pwdata, pstrb);
      if (hit_43) pin_mux_control_word_43 <= merge_bytes(pin_mux_control_word_43, pwdata, pstrb);
      if (hit_44) pin_mux_control_word_44 <= merge_bytes(pin_mux_control_word_44, pwdata, pstrb);
      if (hit_mode) mode_word <= merge_bytes(mode_word, pwdata, pstrb);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= read_mux;
    end
  end

  // ---------------------------------------------------------------
  // Per-unit fields, gating and routing
  // ---------------------------------------------------------------
  for (genvar u = 0; u < UNITS; u++) begin : g_unit
    localparam int POS = (u % 4) * `CG_ENABLE_STEP;
    if (u < 4) begin : g_low
      assign enable_bit[u] = pin_mux_control_word_39[POS];
      assign select_code[u] = pin_mux_control_word_43[POS +: `CG_SELECT_WIDTH];
    end else begin : g_high
      assign enable_bit[u] = pin_mux_control_word_40[POS];
      assign select_code[u] = pin_mux_control_word_44[POS +: `CG_SELECT_WIDTH];
    end
    assign gate_enable[u] = !reset_n || enable_bit[u];

    capture_unit_clock_gate u_gate (
      .clock(clock),
      .enable(gate_enable[u]),
      .gated_clock(capture_unit_clock[u])
    );

    input_sync_filter #(
      .FILTER_CYCLES(FILTER_CYCLES)
    ) u_filter (
      .clock(clock),
      .reset_n(reset_n),
      .pin(capture_pin[u]),
      .synced(synced[u]),
      .filtered(filtered[u])
    );

    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        capture_input[u] <= 1'b0;
      end else begin
        capture_input[u] <= route_level(select_code[u], synced[u], filtered[u]);
      end
    end
  end

  assign capture_unit_clock_enable = gate_enable;
  assign auxiliary_pulse_output_mode = mode_word[UNITS-1:0];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  reset_forces_on_a: assert property (@(posedge clock)
    !reset_n |-> &capture_unit_clock_enable)
    else $error("clock enable low during reset");
  enable_follows_bit_a: assert property (@(posedge clock) disable iff (!reset_n)
    capture_unit_clock_enable == enable_bit)
    else $error("clock enable differs from control bit");
  unit_isolated_a: assert property (@(posedge clock) disable iff (!reset_n)
    (write_ok && hit_39 && pstrb[0] && !pwdata[0]) |=> !capture_unit_clock_enable[0]
      && capture_unit_clock_enable[5:4] == $past(enable_bit[5:4]))
    else $error("clearing unit 0 enable misbehaved");
  enable_reset_a: assert property (@(posedge clock)
    $rose(reset_n) |-> &enable_bit)
    else $error("enable bits not one after reset");
  sync_route_a: assert property (@(posedge clock) disable iff (!reset_n)
    (select_code[0] == 3'h1) |=> capture_input[0] == $past(synced[0]))
    else $error("sync route wrong");
  filter_route_a: assert property (@(posedge clock) disable iff (!reset_n)
    (select_code[0] == 3'h2) |=> capture_input[0] == $past(filtered[0]))
    else $error("filtered route wrong");
  reserved_route_a: assert property (@(posedge clock) disable iff (!reset_n)
    (select_code[1] != 3'h2) |=> capture_input[1] == $past(synced[1]))
    else $error("reserved code not on sync path");
  mode_write_a: assert property (@(posedge clock) disable iff (!reset_n)
    (write_ok && hit_mode && pstrb[0]) |=> auxiliary_pulse_output_mode
      == $past(pwdata[UNITS-1:0]))
    else $error("pulse output mode not written");
endmodule // capture_glue
`default_nettype wire

// >>> capture_source.sv
/*
  Model of the external sources that drive the six capture pins.
  Assumes the bench calls its task from the glue's clock domain.
*/
`timescale 1ns/10ps
`default_nettype none

module capture_source (
  input wire logic clock,
  output logic [5:0] pin
);
  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  initial pin = 6'h00;

  // Sets one pin just after an edge and holds it for the given cycles
  task automatic drive(input int unit, input logic level, input int cycles);
    @(posedge clock);
    pin[unit] <= level;
    repeat (cycles) @(posedge clock);
  endtask
endmodule // capture_source

`default_nettype wire

// >>> tb_capture_glue.sv
/*
  Self-checking bench for the capture unit glue: APB register access,
  clock gating and input routing.
  Assumes the glue, its defs header and the pin source model.
*/
`timescale 1ns/10ps
`default_nettype none
`include "capture_glue_defs.svh"

module tb_capture_glue;
  logic clock;
  logic reset_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] capture_pin;
  logic [5:0] capture_input;
  logic [5:0] capture_unit_clock_enable;
  logic [5:0] capture_unit_clock;
  logic [5:0] auxiliary_pulse_output_mode;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [11:0] offs [5] = '{`CG_OFF_WORD_39, `CG_OFF_WORD_40, `CG_OFF_WORD_43,
                            `CG_OFF_WORD_44, `CG_OFF_MODE};
  logic [31:0] resets [5] = '{32'h01010101, 32'h00000101, 32'h01010101,
                              32'h00000101, 32'h00000000};

  // ---------------------------------------------------------------
  // Design and pin sources
  // ---------------------------------------------------------------
  capture_glue #(.UNITS(6), .FILTER_CYCLES(6)) i_dut (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin(capture_pin), .capture_input(capture_input),
    .capture_unit_clock_enable(capture_unit_clock_enable),
    .capture_unit_clock(capture_unit_clock),
    .auxiliary_pulse_output_mode(auxiliary_pulse_output_mode)
  );
  capture_source i_src (.clock(clock), .pin(capture_pin));

  // ---------------------------------------------------------------
  // Clock, timeout and tasks
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; read data and error taken at the completing edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic test_done();
    if (n_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hf;
    repeat (4) @(posedge clock);
    check("enable_in_reset", {26'h0, capture_unit_clock_enable}, 32'h3f);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, offs[i], 32'h0, 4'hf);
      check("reset_value", rd, resets[i]);
    end
    apb(1'b1, `CG_OFF_WORD_39, 32'h01010100, 4'hf);
    check("enable", {26'h0, capture_unit_clock_enable}, 32'h3e);
    repeat (2) @(posedge clock);
    #2;
    check("unit_clock_high", {26'h0, capture_unit_clock}, 32'h3e);
    #4;
    check("unit_clock_low", {26'h0, capture_unit_clock}, 32'h00);
    apb(1'b1, `CG_OFF_WORD_40, 32'h00000000, 4'h1);
    apb(1'b0, `CG_OFF_WORD_40, 32'h0, 4'hf);
    check("word_40_lane", rd, 32'h00000100);
    check("enable_lane", {26'h0, capture_unit_clock_enable}, 32'h2e);
    @(posedge clock);
    reset_n <= 1'b0;
    #1;
    check("enable_reset_again", {26'h0, capture_unit_clock_enable}, 32'h3f);
    @(posedge clock);
    #2;
    check("unit_clock_reset", {26'h0, capture_unit_clock}, 32'h3f);
    @(posedge clock);
    reset_n <= 1'b1;
    apb(1'b0, `CG_OFF_WORD_39, 32'h0, 4'hf);
    check("word_39_again", rd, 32'h01010101);
    apb(1'b0, 12'h018, 32'h0, 4'hf);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    apb(1'b1, `CG_OFF_STATUS, 32'hffffffff, 4'hf);
    check("status_write_err", {31'h0, err}, 32'h1);
    apb(1'b1, `CG_OFF_MODE, 32'h0000002a, 4'hf);
    check("aux_mode", {26'h0, auxiliary_pulse_output_mode}, 32'h2a);
    i_src.drive(0, 1'b1, 3);
    #1;
    check("sync_rise", {31'h0, capture_input[0]}, 32'h1);
    i_src.drive(0, 1'b0, 3);
    #1;
    check("sync_fall", {31'h0, capture_input[0]}, 32'h0);
    apb(1'b1, `CG_OFF_WORD_43, 32'h01010702, 4'hf);
    i_src.drive(0, 1'b1, 0);
    i_src.drive(0, 1'b0, 12);
    #1;
    check("short_glitch_dropped", {31'h0, capture_input[0]}, 32'h0);
    i_src.drive(0, 1'b1, 3);
    i_src.drive(0, 1'b0, 12);
    #1;
    check("glitch_dropped", {31'h0, capture_input[0]}, 32'h0);
    i_src.drive(0, 1'b1, 6);
    #1;
    check("filter_waits", {31'h0, capture_input[0]}, 32'h0);
    i_src.drive(0, 1'b1, 6);
    #1;
    check("filter_passes", {31'h0, capture_input[0]}, 32'h1);
    i_src.drive(1, 1'b1, 3);
    #1;
    check("reserved_sync", {31'h0, capture_input[1]}, 32'h1);
    apb(1'b0, `CG_OFF_STATUS, 32'h0, 4'hf);
    check("status_synced", {20'h0, rd[11:0]}, 32'h043);
    test_done();
  end
endmodule // tb_capture_glue

`default_nettype wire
